// [irs_pkg.sv]
// Register map, field positions and constants of the raw status bank
package irs_pkg;

    // Printed offsets are word indices (not multiples of four); byte address = 4 * index
    localparam logic [11:0] IRS_IDX_STAT4  = 12'hD22;
    localparam logic [11:0] IRS_IDX_STAT5  = 12'hD23;
    localparam logic [11:0] IRS_IDX_STAT6  = 12'hD24;
    localparam logic [11:0] IRS_IDX_STAT7  = 12'hD25;
    localparam logic [11:0] IRS_IDX_STAT8  = 12'hD26;
    localparam logic [11:0] IRS_IDX_LATCH  = 12'hD30;
    localparam logic [11:0] IRS_IDX_MASK   = 12'hD31;
    localparam logic [11:0] IRS_IDX_CTRL   = 12'hD32;

    localparam int          IRS_ADDR_W     = 14;
    localparam logic [1:0]  IRS_BYTE_LSB   = 2'h0;

    // Raw status 4
    localparam int IRS_S4_ASYNC_OFF  = 9;
    localparam int IRS_S4_MAIN_OFF   = 8;
    localparam int IRS_S4_CONV1_ERR  = 7;
    localparam int IRS_S4_CONV2_ERR  = 6;
    // Raw status 5
    localparam int IRS_S5_BOOT_DONE  = 8;
    localparam int IRS_S5_DAC_SERVO  = 7;
    localparam int IRS_S5_HP_SERVO   = 6;
    localparam int IRS_S5_LOOP2_OK   = 1;
    localparam int IRS_S5_LOOP1_OK   = 0;

    // Implemented bits of the overclock and underclock words
    localparam logic [15:0] IRS_S6_MASK  = 16'h37FF;
    localparam logic [15:0] IRS_S7_MASK  = 16'hFE0B;
    localparam logic [15:0] IRS_S8_MASK  = 16'h077E;

    // Control register: main and second clock enables
    localparam int IRS_CTL_MAIN_EN   = 0;
    localparam int IRS_CTL_ASYNC_EN  = 1;
    localparam logic [15:0] IRS_CTL_RESET = 16'h0003;

    // Event (latched) register bit positions
    localparam int IRS_EV_W          = 8;
    localparam int IRS_EV_BOOT       = 0;
    localparam int IRS_EV_MAIN_OFF   = 1;
    localparam int IRS_EV_ASYNC_OFF  = 2;
    localparam int IRS_EV_CONV_ERR   = 3;
    localparam int IRS_EV_SERVO      = 4;
    localparam int IRS_EV_LOOP_OK    = 5;
    localparam int IRS_EV_OVER       = 6;
    localparam int IRS_EV_UNDER      = 7;

    localparam logic [15:0] IRS_ZERO16 = 16'h0000;

endpackage : irs_pkg

// [irs_sync2.sv]
// Two-flop synchroniser bank for pin-level status inputs
`timescale 1ns/1ps
`default_nettype none

module irs_sync2 #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] stage1_r;
    logic [W-1:0] stage2_r;

    // First stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1_r <= '0;
            stage2_r <= '0;
        end else begin
            stage1_r <= async_in;
            stage2_r <= stage1_r;
        end
    end

    assign sync_out = stage2_r;

endmodule // irs_sync2

`default_nettype wire

// [irs_status_bank.sv]
// APB raw interrupt status bank with summary flags and masked interrupt
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1: Bit 9 reads one once second clock off
// R2: Host waits for second-clock-off before writing
// R3: Bit 8 reads one once main clock off
// R4: Host waits for main-clock-off before writing
// R5: Converter config errors on bits 7 and 6
// R6: Boot done on bit 8 at 0xD23
// R7: Host writes nothing until boot completes
// R8: Servo done: DAC bit 7, headphone bit 6
// R9: Loop clock good: two bit 1, one bit 0
// R10: Per-subsystem overclock flags at 0xD24, 0xD25
// R11: Overrate summary is OR of overclock flags
// R12: Underclock flags at 0xD26, bits 10-8, 6-1
// R13: Underrate summary is OR of underclock flags
// R14: Raw status bits are live, writes ignored
module irs_status_bank
    import irs_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [IRS_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  main_clock_off_ack,
    input  wire logic                  second_clock_off_ack,
    input  wire logic                  interp_converter_one_cfg_error,
    input  wire logic                  interp_converter_two_cfg_error,
    input  wire logic                  startup_complete_flag,
    input  wire logic                  dac_offset_servo_complete,
    input  wire logic                  headphone_offset_servo_complete,
    input  wire logic                  loop_one_clock_good,
    input  wire logic                  loop_two_clock_good,
    input  wire logic [15:0]           overrate_flags_lo,
    input  wire logic [15:0]           overrate_flags_hi,
    input  wire logic [15:0]           underrate_flags,
    output logic                       main_domain_clock_enable,
    output logic                       second_domain_clock_enable,
    output logic                       any_overrate_summary,
    output logic                       any_underrate_summary,
    output logic                       irq
);

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    localparam int NSRC = 57;

    logic [NSRC-1:0] src_raw;
    logic [NSRC-1:0] src_s;

    assign src_raw = {underrate_flags, overrate_flags_hi, overrate_flags_lo,
                      loop_two_clock_good, loop_one_clock_good,
                      headphone_offset_servo_complete, dac_offset_servo_complete,
                      startup_complete_flag, interp_converter_two_cfg_error,
                      interp_converter_one_cfg_error, second_clock_off_ack,
                      main_clock_off_ack};

    irs_sync2 #(.W(NSRC)) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (src_raw),
        .sync_out (src_s)
    );

    wire logic        main_off_s  = src_s[0];
    wire logic        async_off_s = src_s[1];
    wire logic        conv1_s     = src_s[2];
    wire logic        conv2_s     = src_s[3];
    wire logic        boot_s      = src_s[4];
    wire logic        dac_srv_s   = src_s[5];
    wire logic        hp_srv_s    = src_s[6];
    wire logic        loop1_s     = src_s[7];
    wire logic        loop2_s     = src_s[8];
    wire logic [15:0] over_lo_s   = src_s[24:9];
    wire logic [15:0] over_hi_s   = src_s[40:25];
    wire logic [15:0] under_s     = src_s[56:41];

    // ------------------------------------------------------------
    // Raw status words
    // ------------------------------------------------------------
    logic [15:0] stat4;
    logic [15:0] stat5;
    logic [15:0] stat6;
    logic [15:0] stat7;
    logic [15:0] stat8;
    logic [15:0] ctrl_r;

    // Off flags read one only when the enable is low and the clock has stopped
    wire logic async_off_flag = ~ctrl_r[IRS_CTL_ASYNC_EN] & async_off_s; // R1
    wire logic main_off_flag  = ~ctrl_r[IRS_CTL_MAIN_EN] & main_off_s;   // R3

    always_comb begin
        stat4 = IRS_ZERO16;
        stat4[IRS_S4_ASYNC_OFF] = async_off_flag; // R1
        stat4[IRS_S4_MAIN_OFF]  = main_off_flag;  // R3
        stat4[IRS_S4_CONV1_ERR] = conv1_s;        // R5
        stat4[IRS_S4_CONV2_ERR] = conv2_s;        // R5
    end

    always_comb begin
        stat5 = IRS_ZERO16;
        stat5[IRS_S5_BOOT_DONE] = boot_s;    // R6
        stat5[IRS_S5_DAC_SERVO] = dac_srv_s; // R8
        stat5[IRS_S5_HP_SERVO]  = hp_srv_s;  // R8
        stat5[IRS_S5_LOOP2_OK]  = loop2_s;   // R9
        stat5[IRS_S5_LOOP1_OK]  = loop1_s;   // R9
    end

    assign stat6 = over_lo_s & IRS_S6_MASK; // R10
    assign stat7 = over_hi_s & IRS_S7_MASK; // R10
    assign stat8 = under_s & IRS_S8_MASK;   // R12

    wire logic over_any  = |{stat6, stat7}; // R11
    wire logic under_any = |stat8;          // R13

    logic over_sum_r;
    logic under_sum_r;
    logic irq_r;

    // ------------------------------------------------------------
    // Event detection and sticky latch
    // ------------------------------------------------------------
    logic [IRS_EV_W-1:0] level_now;
    logic [IRS_EV_W-1:0] level_prev_r;
    logic [IRS_EV_W-1:0] latch_r;
    logic [IRS_EV_W-1:0] latch_nxt;
    logic [IRS_EV_W-1:0] mask_r;
    logic [IRS_EV_W-1:0] rise;
    logic [31:0]         prdata_r;

    always_comb begin
        level_now = '0;
        level_now[IRS_EV_BOOT]      = boot_s;
        level_now[IRS_EV_MAIN_OFF]  = main_off_flag;
        level_now[IRS_EV_ASYNC_OFF] = async_off_flag;
        level_now[IRS_EV_CONV_ERR]  = conv1_s | conv2_s;
        level_now[IRS_EV_SERVO]     = dac_srv_s & hp_srv_s;
        level_now[IRS_EV_LOOP_OK]   = loop1_s | loop2_s;
        level_now[IRS_EV_OVER]      = over_any;
        level_now[IRS_EV_UNDER]     = under_any;
    end

    assign rise = level_now & ~level_prev_r;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire logic [11:0] word_idx = paddr[IRS_ADDR_W-1:2];
    wire logic        access   = psel & penable;
    wire logic        wr_en    = access & pwrite;
    wire logic        rd_en    = access & ~pwrite;

    wire logic hit_s4    = (word_idx == IRS_IDX_STAT4);
    wire logic hit_s5    = (word_idx == IRS_IDX_STAT5);
    wire logic hit_s6    = (word_idx == IRS_IDX_STAT6);
    wire logic hit_s7    = (word_idx == IRS_IDX_STAT7);
    wire logic hit_s8    = (word_idx == IRS_IDX_STAT8);
    wire logic hit_latch = (word_idx == IRS_IDX_LATCH);
    wire logic hit_mask  = (word_idx == IRS_IDX_MASK);
    wire logic hit_ctrl  = (word_idx == IRS_IDX_CTRL);

    wire logic hit_raw   = hit_s4 | hit_s5 | hit_s6 | hit_s7 | hit_s8;
    wire logic mapped    = hit_raw | hit_latch | hit_mask | hit_ctrl;
    wire logic lo_lanes  = pstrb[0] | pstrb[1];

    // Raw words are read-only; a write to them is silently dropped
    wire logic wr_mask   = wr_en & hit_mask & lo_lanes;
    wire logic wr_ctrl   = wr_en & hit_ctrl & lo_lanes;
    wire logic rd_latch  = rd_en & hit_latch;

    // Set beats a clear-on-read landing in the same cycle; only the bits that the
    // read returned are cleared, so an event landing after the capture is kept
    genvar gi;
    generate
        for (gi = 0; gi < IRS_EV_W; gi = gi + 1) begin : g_evt
            wire logic clr_bit = rd_latch & prdata_r[gi];
            assign latch_nxt[gi] = rise[gi] | (latch_r[gi] & ~clr_bit);
        end
    endgenerate

    // Byte-lane merge for 16-bit writable words
    function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0]  st);
        lane_merge = old;
        if (st[0]) begin
            lane_merge[7:0] = wd[7:0];
        end
        if (st[1]) begin
            lane_merge[15:8] = wd[15:8];
        end
    endfunction

    logic [15:0] mask16_nxt;
    assign mask16_nxt = lane_merge({8'h00, mask_r}, pwdata, pstrb);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_prev_r <= '0;
            latch_r      <= '0;
        end else begin
            level_prev_r <= level_now;
            latch_r      <= latch_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= '0;
        end else if (wr_mask) begin
            mask_r <= mask16_nxt[IRS_EV_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= IRS_CTL_RESET;
        end else if (wr_ctrl) begin
            ctrl_r <= lane_merge(ctrl_r, pwdata, pstrb) & IRS_CTL_RESET;
        end
    end

    assign main_domain_clock_enable   = ctrl_r[IRS_CTL_MAIN_EN];
    assign second_domain_clock_enable = ctrl_r[IRS_CTL_ASYNC_EN];

    // Level outputs leave from flops so the pins never glitch while flags settle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            over_sum_r  <= 1'b0;
            under_sum_r <= 1'b0;
            irq_r       <= 1'b0;
        end else begin
            over_sum_r  <= over_any;  // R11
            under_sum_r <= under_any; // R13
            // Mask bit set enables the event onto the interrupt line
            irq_r       <= |(latch_r & mask_r);
        end
    end

    assign any_overrate_summary  = over_sum_r;
    assign any_underrate_summary = under_sum_r;
    assign irq                   = irq_r;

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    wire logic [15:0] rd_s4    = hit_s4 ? stat4 : IRS_ZERO16; // R14
    wire logic [15:0] rd_s5    = hit_s5 ? stat5 : IRS_ZERO16; // R14
    wire logic [15:0] rd_s6    = hit_s6 ? stat6 : IRS_ZERO16; // R14
    wire logic [15:0] rd_s7    = hit_s7 ? stat7 : IRS_ZERO16; // R14
    wire logic [15:0] rd_s8    = hit_s8 ? stat8 : IRS_ZERO16; // R14
    wire logic [15:0] rd_ev    = hit_latch ? {8'h00, latch_r} : IRS_ZERO16;
    wire logic [15:0] rd_msk   = hit_mask ? {8'h00, mask_r} : IRS_ZERO16;
    wire logic [15:0] rd_ctl   = hit_ctrl ? ctrl_r : IRS_ZERO16;
    // Decodes are one-hot, so the words merge by OR; unmapped reads return zero
    wire logic [15:0] rd_word  = rd_s4 | rd_s5 | rd_s6 | rd_s7 | rd_s8 | rd_ev | rd_msk | rd_ctl;
    wire logic        rd_setup = psel & ~penable & ~pwrite;

    // Captured at the end of setup so the word stands unchanged through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= '0;
        end else if (rd_setup) begin
            prdata_r <= {IRS_ZERO16, rd_word};
        end
    end

    // Zero wait states; unmapped or misaligned accesses report an error
    assign pready  = 1'b1;
    assign pslverr = access & (~mapped | (paddr[1:0] != IRS_BYTE_LSB));
    assign prdata  = prdata_r;

endmodule // irs_status_bank

`default_nettype wire

// [irs_status_bank_assertions.sv]
// Concurrent checks on the ports of the raw status bank
`timescale 1ns/1ps
`default_nettype none

module irs_status_bank_assertions
    import irs_pkg::*;
(
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [IRS_ADDR_W-1:0] paddr,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic                  main_clock_off_ack,
    input wire logic                  second_clock_off_ack,
    input wire logic [15:0]           overrate_flags_lo,
    input wire logic [15:0]           overrate_flags_hi,
    input wire logic [15:0]           underrate_flags,
    input wire logic                  main_domain_clock_enable,
    input wire logic                  second_domain_clock_enable,
    input wire logic                  any_overrate_summary,
    input wire logic                  any_underrate_summary
);
    // ----------
    // Helpers
    // ----------
    logic [1:0] warm_r;
    wire logic [11:0] idx = paddr[13:2];
    wire logic acc = psel && penable;
    wire logic rd_acc = acc && !pwrite;
    wire logic mapped = (idx >= IRS_IDX_STAT4 && idx <= IRS_IDX_STAT8
        || idx >= IRS_IDX_LATCH && idx <= IRS_IDX_CTRL) && paddr[1:0] == 2'h0;
    wire logic live = warm_r == 2'h3;

    // Three-edge input history means nothing until synchronisers and output flops refill
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) warm_r <= 2'h0;
        else if (warm_r != 2'h3) warm_r <= warm_r + 2'h1;
    end

    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s; psel && !penable; endsequence
    sequence access_s; psel && penable; endsequence

    access_ready_a: assert property (setup_s ##1 access_s |-> pready)
        else $error("access phase not completed at once");
    map_error_a: assert property (acc |-> pslverr == !mapped)
        else $error("slave error does not match the map");
    over_summary_a: assert property (live |-> any_overrate_summary ==
        (|($past(overrate_flags_lo, 3) & IRS_S6_MASK) || |($past(overrate_flags_hi, 3) & IRS_S7_MASK)))
        else $error("overrate summary wrong");
    under_summary_a: assert property (live |-> any_underrate_summary ==
        |($past(underrate_flags, 3) & IRS_S8_MASK)) else $error("underrate summary wrong");
    off_flags_a: assert property (live && rd_acc && idx == IRS_IDX_STAT4 |-> prdata[9:8] ==
        {!second_domain_clock_enable && $past(second_clock_off_ack, 3),
         !main_domain_clock_enable && $past(main_clock_off_ack, 3)}) else $error("off flags wrong");
    over_lo_a: assert property (live && rd_acc && idx == IRS_IDX_STAT6 |->
        prdata == {16'h0000, $past(overrate_flags_lo, 3) & IRS_S6_MASK}) else $error("word six wrong");
    over_hi_a: assert property (live && rd_acc && idx == IRS_IDX_STAT7 |->
        prdata == {16'h0000, $past(overrate_flags_hi, 3) & IRS_S7_MASK}) else $error("word seven wrong");
    under_word_a: assert property (live && rd_acc && idx == IRS_IDX_STAT8 |->
        prdata == {16'h0000, $past(underrate_flags, 3) & IRS_S8_MASK}) else $error("word eight wrong");
    enable_hold_a: assert property (!(acc && pwrite && idx == IRS_IDX_CTRL) |=>
        $stable({main_domain_clock_enable, second_domain_clock_enable})) else $error("enable moved");
endmodule // irs_status_bank_assertions

bind irs_status_bank irs_status_bank_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .main_clock_off_ack, .second_clock_off_ack,
    .overrate_flags_lo, .overrate_flags_hi, .underrate_flags, .main_domain_clock_enable,
    .second_domain_clock_enable, .any_overrate_summary, .any_underrate_summary);

`default_nettype wire

// [tb_top.sv]
// Self-checking testbench of the raw status bank
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import irs_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [IRS_ADDR_W-1:0] paddr = 14'h0000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd_snap;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, irq, err_snap, rdy_snap, last_err;
    logic main_domain_clock_enable, second_domain_clock_enable;
    logic any_overrate_summary, any_underrate_summary;
    logic main_clock_off_ack = 1'b0, second_clock_off_ack = 1'b0;
    logic interp_converter_one_cfg_error = 1'b0, interp_converter_two_cfg_error = 1'b0;
    logic startup_complete_flag = 1'b1, dac_offset_servo_complete = 1'b0;
    logic headphone_offset_servo_complete = 1'b0, loop_one_clock_good = 1'b0;
    logic loop_two_clock_good = 1'b0;
    logic [15:0] overrate_flags_lo = 16'h0000, overrate_flags_hi = 16'h0000;
    logic [15:0] underrate_flags = 16'h0000;
    logic [15:0] lo_t [4] = '{16'hFFFF, 16'hC800, 16'h0001, 16'h0000};
    logic [15:0] hi_t [4] = '{16'hFFFF, 16'h01F4, 16'h0000, 16'h0000};
    logic [15:0] un_t [4] = '{16'hFFFF, 16'hF881, 16'h0000, 16'h0002};
    int failures = 0;
    int samples_checked = 0;

    always #2.5 pclk = ~pclk;
    // Outputs are taken mid-cycle, where they are settled, and used at the next rising edge
    always @(negedge pclk) begin
        rd_snap <= prdata;
        err_snap <= pslverr;
        rdy_snap <= pready;
    end

    irs_status_bank dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .main_clock_off_ack, .second_clock_off_ack,
        .interp_converter_one_cfg_error, .interp_converter_two_cfg_error, .startup_complete_flag,
        .dac_offset_servo_complete, .headphone_offset_servo_complete, .loop_one_clock_good,
        .loop_two_clock_good, .overrate_flags_lo, .overrate_flags_hi, .underrate_flags,
        .main_domain_clock_enable, .second_domain_clock_enable, .any_overrate_summary,
        .any_underrate_summary, .irq);

    // ----------
    // Tasks
    // ----------
    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (rdy_snap !== 1'b1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        if (n == 50) failures++;
        rd = rd_snap;
        last_err = err_snap;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [11:0] idx, input logic [31:0] exp);
        logic [31:0] v;
        apb(1'b0, idx, 32'h0000_0000, v);
        check($sformatf("register %h", idx), v, exp);
    endtask

    task automatic wr(input logic [11:0] idx, input logic [31:0] d);
        logic [31:0] v;
        apb(1'b1, idx, d, v);
    endtask

    task automatic wait_irq(input logic lvl);
        @(negedge pclk);
        for (int n = 0; n < 20 && irq !== lvl; n++) @(negedge pclk);
        check("irq", 32'(irq), 32'(lvl));
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ----------
    // Tests
    // ----------
    initial begin
        int n;
        logic [31:0] v;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        rchk(IRS_IDX_STAT5, 32'h0000_0100);
        rchk(IRS_IDX_STAT4, 32'h0000_0000);
        for (int i = 4; i < 7; i++) rchk(IRS_IDX_STAT4 + 12'(i - 2), 32'h0000_0000);
        rchk(IRS_IDX_CTRL, 32'h0000_0003);
        $display("test reset done");
        for (int p = 0; p < 2; p++) begin
            @(posedge pclk);
            interp_converter_one_cfg_error <= p[0];
            interp_converter_two_cfg_error <= !p[0];
            dac_offset_servo_complete <= p[0];
            headphone_offset_servo_complete <= !p[0];
            loop_one_clock_good <= p[0];
            loop_two_clock_good <= !p[0];
            repeat (2) @(posedge pclk);
            rchk(IRS_IDX_STAT4, p ? 32'h0000_0080 : 32'h0000_0040);
            rchk(IRS_IDX_STAT5, p ? 32'h0000_0181 : 32'h0000_0142);
        end
        $display("test status bits done");
        for (int k = 0; k < 4; k++) begin
            @(posedge pclk);
            overrate_flags_lo <= lo_t[k];
            overrate_flags_hi <= hi_t[k];
            underrate_flags <= un_t[k];
            repeat (3) @(posedge pclk);
            @(negedge pclk);
            check("over summary", 32'(any_overrate_summary),
                32'(|(lo_t[k] & IRS_S6_MASK) || |(hi_t[k] & IRS_S7_MASK)));
            check("under summary", 32'(any_underrate_summary), 32'(|(un_t[k] & IRS_S8_MASK)));
            rchk(IRS_IDX_STAT6, {16'h0000, lo_t[k] & IRS_S6_MASK});
            rchk(IRS_IDX_STAT7, {16'h0000, hi_t[k] & IRS_S7_MASK});
            rchk(IRS_IDX_STAT8, {16'h0000, un_t[k] & IRS_S8_MASK});
        end
        $display("test overrate underrate done");
        @(posedge pclk);
        underrate_flags <= 16'h0000;
        interp_converter_one_cfg_error <= 1'b0;
        wr(IRS_IDX_STAT6, 32'h0000_FFFF);
        wr(IRS_IDX_STAT8, 32'h0000_FFFF);
        rchk(IRS_IDX_STAT6, 32'h0000_0000);
        rchk(IRS_IDX_STAT8, 32'h0000_0000);
        rchk(12'hD27, 32'h0000_0000);
        check("unmapped error", 32'(last_err), 32'h0000_0001);
        $display("test read only done");
        pstrb <= 4'hC;
        wr(IRS_IDX_CTRL, 32'h0000_0000);
        pstrb <= 4'hF;
        rchk(IRS_IDX_CTRL, 32'h0000_0003);
        wr(IRS_IDX_CTRL, 32'h0000_0000);
        @(negedge pclk);
        check("enables", 32'({main_domain_clock_enable, second_domain_clock_enable}), 32'h0);
        rchk(IRS_IDX_STAT4, 32'h0000_0000);
        @(posedge pclk);
        main_clock_off_ack <= 1'b1;
        second_clock_off_ack <= 1'b1;
        n = 0;
        do begin
            apb(1'b0, IRS_IDX_STAT4, 32'h0000_0000, v);
            n++;
        end while (v[9:8] !== 2'h3 && n < 10);
        check("off flags", v, 32'h0000_0300);
        wr(IRS_IDX_CTRL, 32'h0000_0003);
        rchk(IRS_IDX_STAT4, 32'h0000_0000);
        @(posedge pclk);
        main_clock_off_ack <= 1'b0;
        second_clock_off_ack <= 1'b0;
        $display("test clock shutdown done");
        repeat (4) @(posedge pclk);
        apb(1'b0, IRS_IDX_LATCH, 32'h0000_0000, v);
        @(posedge pclk);
        underrate_flags <= 16'h0400;
        repeat (6) @(posedge pclk);
        wait_irq(1'b0);
        wr(IRS_IDX_MASK, 32'h0000_0080);
        wait_irq(1'b1);
        rchk(IRS_IDX_LATCH, 32'h0000_0080);
        wait_irq(1'b0);
        $display("test interrupt done");
        wrap_up();
    end

    initial begin
        repeat (5000) @(posedge pclk);
        failures++;
        wrap_up();
    end
endmodule // tb_top

`default_nettype wire
